/* File: core/ddl_host.sv */
// host controller that drives the dual converter load pins
// Function
// - select low writes the first channel, high writes the second
// - two-cycle update: write one, then write other with load low
// - deferred update: two writes, then a separate load cycle
// - tied select and load strobe: second channel written first, both loaded with the first
`timescale 1ns/1ns
`default_nettype none
module ddl_host
   import ddl_pkg::*;
(
   // clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_rst_n,
   // update request
   input  wire logic              i_req,
   input  wire ddl_mode_t         i_mode,
   input  wire logic [DATA_W-1:0] i_code_first,
   input  wire logic [DATA_W-1:0] i_code_second,
   output logic                   o_busy,
   output logic                   o_done,
   // converter pins
   output logic [DATA_W-1:0]      o_data,
   output logic                   o_chan_sel,
   output logic                   o_write_strobe_n,
   output logic                   output_load_strobe_n
);
   ddl_state_t        state_reg;
   ddl_mode_t         mode_reg;
   logic [3:0]        cnt_reg;
   logic [DATA_W-1:0] second_reg;
   logic              cnt_end;

   assign cnt_end = (cnt_reg == CNT_ONE) || (cnt_reg == CNT_ZERO);

   // sequencer; each phase lasts STROBE_CYC clocks, but in ST_WR2 the write strobe is low for one clock fewer
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_reg            <= ST_IDLE;
         mode_reg             <= MODE_TWO_CYCLE;
         cnt_reg              <= CNT_ZERO;
         second_reg           <= DATA_RST;
         o_busy               <= 1'b0;
         o_done               <= 1'b0;
         o_data               <= DATA_RST;
         o_chan_sel           <= SEL_FIRST;
         o_write_strobe_n     <= STROBE_OFF;
         output_load_strobe_n <= STROBE_OFF;
      end else begin
         o_done <= 1'b0;
         if (cnt_reg != CNT_ZERO) begin
            cnt_reg <= cnt_reg - CNT_ONE;
         end
         case (state_reg)
            ST_IDLE: begin
               if (i_req) begin
                  mode_reg   <= i_mode;
                  second_reg <= i_code_second;
                  o_busy     <= 1'b1;
                  cnt_reg    <= STROBE_CYC;
                  if (i_mode == MODE_LOAD_ONLY) begin
                     state_reg            <= ST_LOAD;
                     output_load_strobe_n <= STROBE_ON;
                  end else begin
                     state_reg <= ST_SETUP1;
                     // tied strobe: second channel first, so select high
                     o_chan_sel <= (i_mode == MODE_TIED_STROBE) ?
                                   SEL_SECOND : SEL_FIRST;
                     o_data <= (i_mode == MODE_TIED_STROBE) ?
                               i_code_second : i_code_first;
                     output_load_strobe_n <= (i_mode == MODE_TIED_STROBE) ?
                                             STROBE_OFF : STROBE_OFF;
                  end
               end
            end
            ST_SETUP1: begin
               if (cnt_end) begin
                  state_reg        <= ST_WR1;
                  cnt_reg          <= STROBE_CYC;
                  o_write_strobe_n <= STROBE_ON;
               end
            end
            ST_WR1: begin
               if (cnt_end) begin
                  state_reg        <= ST_SETUP2;
                  cnt_reg          <= STROBE_CYC;
                  o_write_strobe_n <= STROBE_OFF; // data held stable here
               end
            end
            ST_SETUP2: begin
               if (cnt_end) begin
                  state_reg <= ST_WR2;
                  cnt_reg   <= STROBE_CYC;
                  // change select and data only with write strobe high
                  if (mode_reg == MODE_TIED_STROBE) begin
                     o_chan_sel           <= SEL_FIRST;
                     output_load_strobe_n <= STROBE_ON;
                     o_data               <= i_code_first;
                  end else begin
                     o_chan_sel <= SEL_SECOND;
                     o_data     <= second_reg;
                  end
               end else if (cnt_reg == STROBE_CYC) begin
                  o_data <= o_data;
               end
            end
            ST_WR2: begin
               // strobe falls one clock after select and data have moved
               o_write_strobe_n <= STROBE_ON;
               if (mode_reg == MODE_TWO_CYCLE) begin
                  output_load_strobe_n <= STROBE_ON;
               end
               if (cnt_end && !o_write_strobe_n) begin
                  o_write_strobe_n     <= STROBE_OFF;
                  output_load_strobe_n <= STROBE_OFF;
                  cnt_reg              <= STROBE_CYC;
                  state_reg <= (mode_reg == MODE_DEFERRED) ? ST_LOAD : ST_GAP;
                  if (mode_reg == MODE_DEFERRED) begin
                     output_load_strobe_n <= STROBE_ON;
                  end
               end
            end
            ST_LOAD: begin
               if (cnt_end && !output_load_strobe_n) begin
                  output_load_strobe_n <= STROBE_OFF;
                  cnt_reg              <= STROBE_CYC;
                  state_reg            <= ST_GAP;
               end
            end
            ST_GAP: begin
               if (cnt_end) begin
                  state_reg  <= ST_IDLE;
                  o_busy     <= 1'b0;
                  o_done     <= 1'b1;
                  o_chan_sel <= SEL_FIRST;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // window bounds for the sequence checks, in clocks
   // generous on purpose: they catch a stalled sequencer, not a slow one
   localparam int DONE_WAIT_MAX   = 20;
   localparam int SECOND_WAIT_MAX = 15;

   // write strobe never falls while select changes in the same cycle
   a_sel_stable_wr: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !o_write_strobe_n |-> $stable(o_chan_sel))
      else $error("select changed during write strobe");
   a_data_stable_wr: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (!o_write_strobe_n && !$fell(o_write_strobe_n)) |-> $stable(o_data))
      else $error("data changed during write strobe");
   a_load_only_gap: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (state_reg == ST_LOAD) |-> o_write_strobe_n)
      else $error("write strobe active during deferred load");
   // tied strobe: second channel written while load is held high
   sequence s_tied_second;
      o_chan_sel == SEL_SECOND && !o_write_strobe_n && output_load_strobe_n;
   endsequence
   a_tied_order: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (mode_reg == MODE_TIED_STROBE && state_reg == ST_WR1) |-> s_tied_second)
      else $error("tied strobe mode loaded first channel first");
   a_two_cycle_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (mode_reg == MODE_TWO_CYCLE && !output_load_strobe_n) |->
      (o_chan_sel == SEL_SECOND))
      else $error("two-cycle load outside second write");
   a_load_rise_done: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      $rose(output_load_strobe_n) |-> ##[1:DONE_WAIT_MAX] o_done)
      else $error("no completion after load edge");
   a_idle_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (state_reg == ST_IDLE && !i_req) |=> o_write_strobe_n
      && output_load_strobe_n)
      else $error("strobe active while idle");
   a_wr_width: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      $fell(o_write_strobe_n) |-> !o_write_strobe_n [*4])
      else $error("write strobe too short");

   // tied mode: while a write is open, load and select move as one line
   a_tied_couple: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (mode_reg == MODE_TIED_STROBE && !o_write_strobe_n) |->
      (output_load_strobe_n == o_chan_sel))
      else $error("tied load and select drifted apart");
   // tied mode: first channel follows with load low once the second is in
   sequence s_tied_first;
      o_chan_sel == SEL_FIRST && !o_write_strobe_n && !output_load_strobe_n;
   endsequence
   a_tied_steps: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (mode_reg == MODE_TIED_STROBE && $rose(o_write_strobe_n) &&
      o_chan_sel == SEL_SECOND) |-> ##[1:SECOND_WAIT_MAX] s_tied_first)
      else $error("tied mode first channel write missing");

   // two-cycle: the second write carries the load strobe
   sequence s_second_with_load;
      o_chan_sel == SEL_SECOND && !o_write_strobe_n && !output_load_strobe_n;
   endsequence
   a_two_cycle_steps: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (mode_reg == MODE_TWO_CYCLE && $rose(o_write_strobe_n) &&
      o_chan_sel == SEL_FIRST) |-> ##[1:SECOND_WAIT_MAX] s_second_with_load)
      else $error("second write did not carry the load");

   // deferred: load stays off while writes run, then comes alone
   sequence s_load_alone;
      o_write_strobe_n && !output_load_strobe_n;
   endsequence
   a_deferred_split: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (mode_reg == MODE_DEFERRED && !output_load_strobe_n) |-> o_write_strobe_n)
      else $error("deferred load overlapped a write");
   a_deferred_steps: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (mode_reg == MODE_DEFERRED && $rose(o_write_strobe_n) &&
      o_chan_sel == SEL_SECOND) |-> s_load_alone)
      else $error("deferred load did not follow second write");
endmodule : ddl_host
`default_nettype wire

/* File: core/ddl_pkg.sv */
// constants for the host-side dual converter load controller
package ddl_pkg;
   localparam int unsigned DATA_W        = 12;
   localparam logic        SEL_FIRST     = 1'h0;
   localparam logic        SEL_SECOND    = 1'h1;
   localparam logic        STROBE_ON     = 1'h0;
   localparam logic        STROBE_OFF    = 1'h1;
   localparam logic [11:0] CODE_MIDSCALE = 12'h800;
   localparam logic [11:0] CODE_TOP      = 12'hfff;
   localparam logic [11:0] CODE_BOTTOM   = 12'h000;
   localparam logic [11:0] DATA_RST      = 12'h000;
   // strobe low width and setup/hold spacing, in ns
   localparam int unsigned T_STROBE_NS   = 50;
   localparam int unsigned CLK_NS        = 10;
   localparam logic [3:0]  STROBE_CYC    =
      4'((T_STROBE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0]  CNT_ZERO      = 4'h0;
   localparam logic [3:0]  CNT_ONE       = 4'h1;

   typedef enum logic [1:0] {
      MODE_TWO_CYCLE   = 2'b00,
      MODE_DEFERRED    = 2'b01,
      MODE_LOAD_ONLY   = 2'b10,
      MODE_TIED_STROBE = 2'b11
   } ddl_mode_t;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_SETUP1 = 3'b001,
      ST_WR1    = 3'b010,
      ST_SETUP2 = 3'b011,
      ST_WR2    = 3'b100,
      ST_LOAD   = 3'b101,
      ST_GAP    = 3'b110
   } ddl_state_t;
endpackage : ddl_pkg

/* File: sim/ddl_dev_model.sv */
// behavioural model of the dual converter register pair
`timescale 1ns/1ns
`default_nettype none
module ddl_dev_model
   import ddl_pkg::*;
(
   // converter pins
   input  wire logic [DATA_W-1:0] i_data,
   input  wire logic              i_chan_sel,
   input  wire logic              i_write_strobe_n,
   input  wire logic              i_load_strobe_n,
   // converter register contents
   output logic [DATA_W-1:0]      o_dac_first,
   output logic [DATA_W-1:0]      o_dac_second
);
   // zero start is model convenience only, nothing relies on it
   logic [DATA_W-1:0] in_first_reg  = DATA_RST;
   logic [DATA_W-1:0] in_second_reg = DATA_RST;
   // input latches follow data while write strobe low, else hold
   always @* begin
      if (i_write_strobe_n == STROBE_ON && i_chan_sel == SEL_FIRST) in_first_reg = i_data;
      if (i_write_strobe_n == STROBE_ON && i_chan_sel == SEL_SECOND) in_second_reg = i_data;
   end
   // both converter latches open together, hold from load rising edge
   always @* begin
      if (i_load_strobe_n == STROBE_ON) begin
         o_dac_first  = in_first_reg;
         o_dac_second = in_second_reg;
      end
   end
endmodule : ddl_dev_model
`default_nettype wire

/* File: sim/tb_top.sv */
// self-checking bench for the host load controller
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import ddl_pkg::*;
   logic              i_clk = 1'b0, i_rst_n = 1'b0, i_req = 1'b0;
   ddl_mode_t         i_mode = MODE_TWO_CYCLE;
   logic [DATA_W-1:0] i_code_first = 12'h000, i_code_second = 12'h000;
   logic              o_busy, o_done, o_chan_sel, o_write_strobe_n, output_load_strobe_n;
   logic [DATA_W-1:0] o_data, dac_first, dac_second, exp_first, exp_second;
   logic [19:0]       lfsr = 20'h17162;
   logic              primed = 1'b0;
   int                error_cnt = 0, n_tests = 0, cyc = 0;
   ddl_host dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(i_req), .i_mode(i_mode),
      .i_code_first(i_code_first), .i_code_second(i_code_second), .o_busy(o_busy),
      .o_done(o_done), .o_data(o_data), .o_chan_sel(o_chan_sel),
      .o_write_strobe_n(o_write_strobe_n), .output_load_strobe_n(output_load_strobe_n));
   ddl_dev_model dev_u (.i_data(o_data), .i_chan_sel(o_chan_sel),
      .i_write_strobe_n(o_write_strobe_n), .i_load_strobe_n(output_load_strobe_n),
      .o_dac_first(dac_first), .o_dac_second(dac_second));
   always #5 i_clk = ~i_clk;
   // hang guard, a run needs well under a thousand cycles
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         error_cnt++;
         conclude();
      end
   end
   function automatic logic [19:0] nxt(input logic [19:0] s);
      return {s[18:0], s[19] ^ s[16]};
   endfunction : nxt
   task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // one update request, then compare converter contents with the expected codes
   task automatic run(input ddl_mode_t m, input logic [11:0] a, input logic [11:0] b);
      int k;
      logic seen_load;
      k = 0;
      seen_load = 1'b0;
      i_code_first = a;
      i_code_second = b;
      i_mode = m;
      i_req = 1'b1;
      @(posedge i_clk);
      #1 i_req = 1'b0;
      chk({11'h000, o_busy}, 12'h001);
      while (o_done !== 1'b1 && k < 100) begin
         @(posedge i_clk);
         #1 k++;
         if (!output_load_strobe_n) seen_load = 1'b1;
         // converter contents hold until this update's first load strobe
         if (primed && !seen_load) chk(dac_first, exp_first);
         if (primed && !seen_load) chk(dac_second, exp_second);
      end
      chk({11'h000, o_done}, 12'h001);
      if (m != MODE_LOAD_ONLY) begin
         exp_first = a;
         exp_second = b;
      end
      chk(dac_first, exp_first);
      chk(dac_second, exp_second);
      chk({9'h000, o_busy, o_write_strobe_n, output_load_strobe_n}, 12'h003);
      // idle first code wanders, first converter contents must hold
      lfsr = nxt(lfsr);
      i_code_first = lfsr[11:0];
      repeat (3) @(posedge i_clk);
      #1 chk(dac_first, exp_first);
      primed = 1'b1;
   endtask : run
   task automatic conclude();
      $display("comparisons %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : conclude
   initial begin
      repeat (12) @(posedge i_clk);
      #1 i_rst_n = 1'b1;
      run(MODE_TWO_CYCLE, CODE_MIDSCALE, CODE_TOP);
      run(MODE_DEFERRED, CODE_BOTTOM, CODE_MIDSCALE);
      for (int i = 0; i < 16; i++) begin
         lfsr = nxt(lfsr);
         run(ddl_mode_t'(i[1:0]), lfsr[11:0], lfsr[19:8]);
      end
      conclude();
   end
endmodule : tb_top
`default_nettype wire
